// [logic/serial_frame_transmitter.sv]
/*
  Serial frame transmitter with AXI4-Lite registers, transmit buffer,
  bit-rate generator, sync clock and a shared-format receive sampler.
  Assumes one 20 MHz clock, synchronous reset, and the port pins outside.
*/
// The AXI4-Lite register port and the register offsets were left to the implementer.
// Behaviour
// R1: Start bit is driven low.
// R2: Every stop bit is driven high.
// R3: Line rests high whenever no frame is sent.
// R4: Transmitter and receiver share size, parity and stop settings.
// R5: Software leaves the frame format alone during traffic.
// R6: Three-bit size field picks five to nine data bits.
// R7: Two-bit parity field picks none, even or odd.
// R8: Stop select picks one or two stop bits.
// R9: Receiver checks only the first stop bit for framing errors.
// R10: Even parity is the XOR of all data bits.
// R11: Odd parity is that XOR inverted.
// R12: Parity bit follows last data bit, before first stop bit.
// R13: Transmitter enable hands the pin to the serial output.
// R14: Sync mode with transmitter enabled takes over the transfer clock pin; the code drives it only when clock_master is also set.
// R15: Writing the data register starts a transmission.
// R16: Buffer moves to shifter when idle or after last stop bit.
// R17: Shifter sends one frame at divisor, double-speed or external rate.
// R18: Data bits above the character size are discarded.
// R19: Software waits for buffer empty before writing.
// R20: Software clears transmit complete before each write if using it.
// R21: Software sets divisor, then format, then enables.
// R22: Software changes rate or format only with no transfer running.
// R23: Start first, then data least significant bit first.
// R24: Buffer empty flag clears on data write, sets when emptied.
// R25: Transmit complete sets after frame with empty buffer; write one clears.
// R26: Ninth bit is written before the low byte.
`timescale 1ns/1ps
`include "frame_tx_defines.svh"
module serial_frame_transmitter (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic [31:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [31:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        port_txd,
  output logic             txd_out,
  output logic             txd_override,
  input  wire logic        rxd_in,
  input  wire logic        transfer_clock_pin_in,
  output logic             transfer_clock_pin_out,
  output logic             transfer_clock_pin_oe
);
  import frame_tx_pkg::*;

  typedef struct packed {
    logic        aw_got;
    logic [7:0]  aw_a;
    logic        w_got;
    logic [7:0]  w_d;
    logic        w_s;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [7:0]  rdata;
    logic        transmitter_enable;
    logic        receiver_enable;
    logic        ninth_transmit_bit;
    logic        double_speed_bit;
    logic        sync_mode;
    logic        clock_master;
    logic        stop_count_select;
    logic [2:0]  char_size_field;
    logic [1:0]  parity_mode_field;
    logic [11:0] baud_divisor;
    logic        buf_full;
    logic        transmit_complete_flag;
    logic        receive_complete_flag;
    logic        framing_error_flag;
    logic [8:0]  buf_d;
    logic [8:0]  sh;
    logic        par;
    tx_state_t   state;
    logic [3:0]  bitn;
    logic        line;
    logic [11:0] pre;
    logic [3:0]  os;
    logic        transfer_clock_pin;
    logic        xs1;
    logic        xs2;
    logic        xsp;
    logic        rs1;
    logic        rs2;
    logic [8:0]  rx_d;
  } regs_t;

  regs_t       st_r;
  regs_t       st_nxt;
  logic        tick;
  logic        os_tick;
  logic        bit_tick;
  logic [3:0]  os_top;
  logic [3:0]  nbits;
  logic        par_en;
  logic        wr_go;
  logic        data_wr;
  logic        load;
  logic        fin;
  logic        rx_done;
  logic [8:0]  rx_data;
  logic        rx_ferr;

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a <= `BAUD_DIVISOR_HIGH_OFS) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [7:0] rd_mux(input regs_t r, input logic [7:0] a);
    rd_mux = 8'h00;
    case (a)
      `DATA_BUFFER_PORT_OFS: rd_mux = r.rx_d[7:0];
      `CONTROL_A_REG_OFS: begin
        rd_mux[`A_EMPTY_POS]    = !r.buf_full;
        rd_mux[`A_TXDONE_POS]   = r.transmit_complete_flag;
        rd_mux[`A_RXDONE_POS]   = r.receive_complete_flag;
        rd_mux[`A_FRAMEERR_POS] = r.framing_error_flag;
        rd_mux[`A_DOUBLE_POS]   = r.double_speed_bit;
      end
      `CONTROL_B_REG_OFS: begin
        rd_mux[`B_TRANSMITTER_ENABLE_POS]  = r.transmitter_enable;
        rd_mux[`B_RECEIVER_ENABLE_POS]  = r.receiver_enable;
        rd_mux[`B_TX9_POS]   = r.ninth_transmit_bit;
        rd_mux[`B_SIZE2_POS] = r.char_size_field[2];
        rd_mux[`B_RX9_POS]   = r.rx_d[8];
      end
      `CONTROL_C_REG_OFS: begin
        rd_mux[`C_SIZE_POS +: 2]   = r.char_size_field[1:0];
        rd_mux[`C_PARITY_POS +: 2] = r.parity_mode_field;
        rd_mux[`C_STOP_POS]        = r.stop_count_select;
        rd_mux[`C_SYNC_POS]        = r.sync_mode;
        rd_mux[`C_MASTER_POS]      = r.clock_master;
      end
      `BAUD_DIVISOR_LOW_OFS:  rd_mux = r.baud_divisor[7:0];
      `BAUD_DIVISOR_HIGH_OFS: rd_mux = {4'h0, r.baud_divisor[11:8]};
      default: rd_mux = 8'h00;
    endcase
  endfunction

  always_comb begin
    st_nxt  = st_r;
    load    = 1'b0;
    fin     = 1'b0;
    nbits   = char_bits(st_r.char_size_field); // R6
    par_en  = st_r.parity_mode_field[1]; // R7
    st_nxt.xs1 = transfer_clock_pin_in;
    st_nxt.xs2 = st_r.xs1;
    st_nxt.xsp = st_r.xs2;
    st_nxt.rs1 = rxd_in;
    st_nxt.rs2 = st_r.rs1;

    // Bit-rate generation
    tick       = (st_r.pre == 12'h000);
    st_nxt.pre = tick ? st_r.baud_divisor : st_r.pre - 12'h001;
    os_top     = st_r.double_speed_bit ? `OS_TOP_DOUBLE : `OS_TOP_NORMAL;
    os_tick    = tick && !st_r.sync_mode;
    if (os_tick) begin
      st_nxt.os = (st_r.os == os_top) ? 4'h0 : st_r.os + 4'h1;
    end
    if (tick && st_r.sync_mode && st_r.clock_master) begin
      st_nxt.transfer_clock_pin = !st_r.transfer_clock_pin;
    end
    // Data changes on the rising transfer clock edge
    if (!st_r.sync_mode) begin
      bit_tick = os_tick && (st_r.os == os_top); // R17
    end else if (st_r.clock_master) begin
      bit_tick = tick && !st_r.transfer_clock_pin; // R17
    end else begin
      bit_tick = st_r.xs2 && !st_r.xsp; // R17
    end

    // Bus slave: address and data taken in either order
    awready = !st_r.aw_got && !st_r.bvalid;
    wready  = !st_r.w_got && !st_r.bvalid;
    arready = !st_r.rvalid;
    if (awvalid && awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.aw_a   = awaddr[7:0];
    end
    if (wvalid && wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.w_d   = wdata[7:0];
      st_nxt.w_s   = wstrb[0];
    end
    wr_go   = st_r.aw_got && st_r.w_got && !st_r.bvalid;
    data_wr = wr_go && st_r.w_s && (st_r.aw_a == `DATA_BUFFER_PORT_OFS);
    if (wr_go) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = addr_ok(st_r.aw_a) ? `RESP_OKAY : `RESP_SLVERR;
      if (st_r.w_s) begin
        case (st_r.aw_a)
          `CONTROL_A_REG_OFS: begin
            st_nxt.double_speed_bit = st_r.w_d[`A_DOUBLE_POS];
            if (st_r.w_d[`A_TXDONE_POS]) begin
              st_nxt.transmit_complete_flag = 1'b0; // R25
            end
          end
          `CONTROL_B_REG_OFS: begin
            st_nxt.transmitter_enable     = st_r.w_d[`B_TRANSMITTER_ENABLE_POS];
            st_nxt.receiver_enable        = st_r.w_d[`B_RECEIVER_ENABLE_POS];
            st_nxt.ninth_transmit_bit     = st_r.w_d[`B_TX9_POS];
            st_nxt.char_size_field[2]     = st_r.w_d[`B_SIZE2_POS];
          end
          `CONTROL_C_REG_OFS: begin
            st_nxt.char_size_field[1:0] = st_r.w_d[`C_SIZE_POS +: 2];
            st_nxt.parity_mode_field    = st_r.w_d[`C_PARITY_POS +: 2];
            st_nxt.stop_count_select    = st_r.w_d[`C_STOP_POS];
            st_nxt.sync_mode            = st_r.w_d[`C_SYNC_POS];
            st_nxt.clock_master         = st_r.w_d[`C_MASTER_POS];
          end
          `BAUD_DIVISOR_LOW_OFS:  st_nxt.baud_divisor[7:0]  = st_r.w_d;
          `BAUD_DIVISOR_HIGH_OFS: st_nxt.baud_divisor[11:8] = st_r.w_d[3:0];
          default: ;
        endcase
      end
    end
    // A write into a full buffer is dropped; software must poll first
    if (data_wr && !st_r.buf_full) begin
      st_nxt.buf_d    = {st_r.ninth_transmit_bit, st_r.w_d}
                        & char_mask(st_r.char_size_field); // R18
      st_nxt.buf_full = 1'b1; // R15 R24
    end
    if (st_r.bvalid && bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (arvalid && arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = addr_ok(araddr[7:0]) ? `RESP_OKAY : `RESP_SLVERR;
      st_nxt.rdata  = rd_mux(st_r, araddr[7:0]);
      if (araddr[7:0] == `DATA_BUFFER_PORT_OFS) begin
        st_nxt.receive_complete_flag = 1'b0;
      end
    end
    if (st_r.rvalid && rready) begin
      st_nxt.rvalid = 1'b0;
    end

    // Frame sequencer
    case (st_r.state)
      st_idle: begin
        load = st_r.transmitter_enable && st_r.buf_full; // R16
      end
      st_start: begin
        if (bit_tick) begin
          st_nxt.state = st_data;
          st_nxt.line  = st_r.sh[0]; // R23
        end
      end
      st_data: begin
        if (bit_tick) begin
          if (st_r.bitn == nbits - 4'h1) begin
            st_nxt.state = par_en ? st_par : st_stop1; // R12
            st_nxt.line  = par_en ? st_r.par : 1'b1; // R12 R2
          end else begin
            st_nxt.sh   = st_r.sh >> 1;
            st_nxt.line = st_r.sh[1]; // R23
            st_nxt.bitn = st_r.bitn + 4'h1;
          end
        end
      end
      st_par: begin
        if (bit_tick) begin
          st_nxt.state = st_stop1;
          st_nxt.line  = 1'b1; // R2
        end
      end
      st_stop1: begin
        if (bit_tick) begin
          if (st_r.stop_count_select) begin
            st_nxt.state = st_stop2; // R8
          end else begin
            fin = 1'b1;
          end
        end
      end
      st_stop2: begin
        fin = bit_tick;
      end
      default: begin
        st_nxt.state = st_idle;
        st_nxt.line  = 1'b1;
      end
    endcase
    // Pending data still goes out after the enable is dropped
    if (fin) begin
      load = st_r.buf_full; // R16
      if (!st_r.buf_full) begin
        st_nxt.state                  = st_idle;
        st_nxt.line                   = 1'b1; // R3
        st_nxt.transmit_complete_flag = 1'b1; // R25
      end
    end
    if (load) begin
      st_nxt.state    = st_start;
      st_nxt.line     = 1'b0; // R1
      st_nxt.sh       = st_r.buf_d;
      st_nxt.bitn     = 4'h0;
      st_nxt.buf_full = 1'b0; // R24
      st_nxt.par      = (^st_r.buf_d) ^ st_r.parity_mode_field[0]; // R10 R11
      if (!st_r.sync_mode && st_r.state == st_idle) begin
        // Restart the divider so the start bit is a full bit long
        st_nxt.os  = 4'h0;
        st_nxt.pre = st_r.baud_divisor;
      end
    end

    // Receive result; a new frame beats a same-cycle read clear
    if (rx_done) begin
      st_nxt.receive_complete_flag = 1'b1;
      st_nxt.rx_d                  = rx_data;
      st_nxt.framing_error_flag    = rx_ferr;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_r                 <= '0;
      st_r.line            <= 1'b1;
      st_r.state           <= st_idle;
      st_r.char_size_field <= `CHAR_SIZE_RST;
      st_r.baud_divisor    <= `DIVISOR_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  frame_sampler u_sampler (
    .sys_clk (sys_clk),
    .srst    (srst),
    .enable  (st_r.receiver_enable && !st_r.sync_mode),
    .os_tick (os_tick),
    .os_top  (os_top),
    .rxd     (st_r.rs2),
    .nbits   (nbits),
    .par_en  (par_en),
    .done    (rx_done),
    .data    (rx_data),
    .ferr    (rx_ferr)
  ); // R4

  assign bvalid                 = st_r.bvalid;
  assign bresp                  = st_r.bresp;
  assign rvalid                 = st_r.rvalid;
  assign rresp                  = st_r.rresp;
  assign rdata                  = {24'h000000, st_r.rdata};
  assign txd_override           = st_r.transmitter_enable || (st_r.state != st_idle); // R13
  assign txd_out                = txd_override ? st_r.line : port_txd;
  assign transfer_clock_pin_out = st_r.transfer_clock_pin;
  assign transfer_clock_pin_oe  = st_r.transmitter_enable && st_r.sync_mode
                                  && st_r.clock_master; // R14

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  property p_start_low;
    st_r.state == st_start |-> txd_out == 1'b0;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit not low"); // R1

  property p_stop_high;
    st_r.state inside {st_stop1, st_stop2} |-> txd_out;
  endproperty
  a_stop_high: assert property (p_stop_high) else $error("stop bit not high"); // R2

  property p_idle_high;
    st_r.state == st_idle && txd_override |-> txd_out;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("idle line low"); // R3

  property p_lsb_first;
    st_r.state == st_start && bit_tick |=> st_r.state == st_data
      && txd_out == $past(st_r.sh[0]);
  endproperty
  a_lsb_first: assert property (p_lsb_first) else $error("first data bit wrong"); // R23

  property p_parity_slot;
    st_r.state == st_data && bit_tick && st_r.bitn == nbits - 4'h1 && par_en
      |=> st_r.state == st_par && txd_out == $past(st_r.par);
  endproperty
  a_parity_slot: assert property (p_parity_slot) else $error("parity misplaced"); // R12

  property p_parity_value;
    load |=> st_r.par == ((^$past(st_r.buf_d)) ^ $past(st_r.parity_mode_field[0]));
  endproperty
  a_parity_value: assert property (p_parity_value) else $error("parity wrong"); // R10 R11

  property p_load_idle;
    st_r.state == st_idle && st_r.transmitter_enable && st_r.buf_full
      |=> st_r.state == st_start && !st_r.buf_full;
  endproperty
  a_load_idle: assert property (p_load_idle) else $error("buffer not loaded"); // R16

  property p_write_fills;
    data_wr && !st_r.buf_full |=> st_r.buf_full || st_r.state == st_start;
  endproperty
  a_write_fills: assert property (p_write_fills) else $error("write lost"); // R15 R24

  property p_complete_set;
    fin && !st_r.buf_full |=> st_r.transmit_complete_flag && st_r.state == st_idle;
  endproperty
  a_complete_set: assert property (p_complete_set) else $error("complete not set"); // R25

  property p_one_stop;
    st_r.state == st_stop1 && bit_tick && !st_r.stop_count_select
      |=> st_r.state != st_stop2;
  endproperty
  a_one_stop: assert property (p_one_stop) else $error("extra stop bit"); // R8

  property p_pin_owned;
    st_r.transmitter_enable |-> txd_override && txd_out == st_r.line;
  endproperty
  a_pin_owned: assert property (p_pin_owned) else $error("pin not overridden"); // R13

endmodule // serial_frame_transmitter

// [logic/frame_tx_defines.svh]
/*
  Register offsets, field positions, reset values and bit-rate counts
  for the serial frame transmitter. Assumes a 32-bit AXI4-Lite slave
  decoding the low address byte.
*/
`ifndef FRAME_TX_DEFINES_SVH
`define FRAME_TX_DEFINES_SVH

`define DATA_BUFFER_PORT_OFS  8'h00
`define CONTROL_A_REG_OFS     8'h04
`define CONTROL_B_REG_OFS     8'h08
`define CONTROL_C_REG_OFS     8'h0c
`define BAUD_DIVISOR_LOW_OFS  8'h10
`define BAUD_DIVISOR_HIGH_OFS 8'h14

`define A_EMPTY_POS    0
`define A_TXDONE_POS   1
`define A_RXDONE_POS   2
`define A_FRAMEERR_POS 3
`define A_DOUBLE_POS   4
`define B_TRANSMITTER_ENABLE_POS     0
`define B_RECEIVER_ENABLE_POS     1
`define B_TX9_POS      2
`define B_SIZE2_POS    3
`define B_RX9_POS      4
`define C_SIZE_POS     0
`define C_PARITY_POS   2
`define C_STOP_POS     4
`define C_SYNC_POS     5
`define C_MASTER_POS   6

`define CHAR_SIZE_RST  3'h3
`define DIVISOR_RST    12'h000
`define OS_TOP_NORMAL  4'hf
`define OS_TOP_DOUBLE  4'h7
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

// [logic/frame_tx_pkg.sv]
/*
  Types and shared decoding for the serial frame transmitter.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package frame_tx_pkg;

  typedef enum logic [2:0] {
    st_idle  = 3'h0,
    st_start = 3'h1,
    st_data  = 3'h3,
    st_par   = 3'h2,
    st_stop1 = 3'h6,
    st_stop2 = 3'h7
  } tx_state_t;

  // Size codes 4..6 are reserved and behave as eight bits
  function automatic logic [3:0] char_bits(input logic [2:0] sz);
    case (sz)
      3'h0:    char_bits = 4'h5;
      3'h1:    char_bits = 4'h6;
      3'h2:    char_bits = 4'h7;
      3'h7:    char_bits = 4'h9;
      default: char_bits = 4'h8;
    endcase
  endfunction

  function automatic logic [8:0] char_mask(input logic [2:0] sz);
    char_mask = 9'h1ff >> (4'h9 - char_bits(sz));
  endfunction

endpackage

// [logic/frame_sampler.sv]
/*
  Receive-side frame sampler sharing the transmitter's frame format.
  Assumes rxd is already synchronised and os_tick is the oversample tick.
*/
`timescale 1ns/1ps
module frame_sampler (
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic       enable,
  input  wire logic       os_tick,
  input  wire logic [3:0] os_top,
  input  wire logic       rxd,
  input  wire logic [3:0] nbits,
  input  wire logic       par_en,
  output logic            done,
  output logic [8:0]      data,
  output logic            ferr
);
  import frame_tx_pkg::*;

  typedef struct packed {
    logic       busy;
    logic       start;
    logic [3:0] cnt;
    logic [3:0] idx;
    logic [8:0] sh;
    logic       done;
    logic [8:0] data;
    logic       ferr;
  } rx_regs_t;

  rx_regs_t st_r;
  rx_regs_t st_nxt;

  always_comb begin
    st_nxt      = st_r;
    st_nxt.done = 1'b0;
    if (!st_r.busy) begin
      if (enable && !rxd) begin
        st_nxt.busy  = 1'b1;
        st_nxt.start = 1'b1;
        st_nxt.cnt   = 4'h0;
      end
    end else if (os_tick) begin
      if (st_r.start) begin
        if (st_r.cnt == (os_top >> 1)) begin
          // A glitch shorter than half a bit is not a start
          st_nxt.busy  = !rxd;
          st_nxt.start = 1'b0;
          st_nxt.cnt   = 4'h0;
          st_nxt.idx   = 4'h0;
        end else begin
          st_nxt.cnt = st_r.cnt + 4'h1;
        end
      end else if (st_r.cnt == os_top) begin
        st_nxt.cnt = 4'h0;
        st_nxt.idx = st_r.idx + 4'h1;
        if (st_r.idx < nbits) begin
          st_nxt.sh = {rxd, st_r.sh[8:1]};
        end else if (!(par_en && st_r.idx == nbits)) begin
          // Only the first stop bit is looked at
          st_nxt.busy = 1'b0;
          st_nxt.done = 1'b1;
          st_nxt.data = st_r.sh >> (4'h9 - nbits);
          st_nxt.ferr = !rxd; // R9
        end
      end else begin
        st_nxt.cnt = st_r.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign done = st_r.done;
  assign data = st_r.data;
  assign ferr = st_r.ferr;

  property p_stop_check;
    @(posedge sys_clk) disable iff (srst) done |-> ferr == !$past(rxd);
  endproperty
  a_stop_check: assert property (p_stop_check) else $error("framing flag wrong"); // R9

endmodule // frame_sampler

// [tb/line_receiver.sv]
/*
  Far-end receiver on the transmit line: samples each bit mid-cell.
  Assumes the bench supplies bit time and frame format, idle only.
*/
`timescale 1ns/1ps
module line_receiver (
  input  wire logic       sys_clk,
  input  wire logic       line,
  input  wire logic [5:0] bit_time,
  input  wire logic [3:0] nbits,
  input  wire logic [1:0] parity_mode,
  input  wire logic       two_stop,
  output logic            got,
  output logic [12:0]     frame
);
  logic [3:0] i;
  task automatic bit_wait(input logic [5:0] n);
    repeat (n) @(posedge sys_clk);
  endtask
  // One process owns both outputs
  initial begin
    got   = 1'b0;
    frame = 13'h0000;
    forever begin
      @(negedge line);
      bit_wait(bit_time >> 1);
      // Short low pulses are glitches, not frames
      if (line === 1'b0) begin
        // Absent parity and second stop read as one
        frame     = 13'h0e00;
        frame[12] = line;
        for (i = 4'h0; i < nbits; i++) begin
          bit_wait(bit_time);
          frame[i] = line;
        end
        if (parity_mode[1]) begin
          bit_wait(bit_time);
          frame[9] = line;
        end
        bit_wait(bit_time);
        frame[10] = line;
        if (two_stop) begin
          bit_wait(bit_time);
          frame[11] = line;
        end
        got <= 1'b1;
        @(posedge sys_clk);
        got <= 1'b0;
      end
    end
  end
endmodule // line_receiver

// [tb/test_serial_frame_transmitter.sv]
/*
  Self-checking bench: bus tasks, frame scoreboard, loopback to rxd.
  Assumes the far-end model line_receiver on the transmit pin.
*/
`timescale 1ns/1ps
module test_serial_frame_transmitter;
  logic        sys_clk, srst, awvalid, wvalid, bready, arvalid, rready, port_txd;
  logic        awready, wready, bvalid, arready, rvalid, txd_out, txd_override;
  logic        xck_out, xck_oe, got, ts;
  logic [31:0] awaddr, wdata, araddr, rdata, q, d, seed;
  logic [3:0]  wstrb, nb;
  logic [1:0]  bresp, rresp, r, pm;
  logic [5:0]  bt;
  logic [7:0]  v;
  logic [12:0] frame;
  logic [31:0] expq[$];
  int          error_cnt = 0;
  int          samples_checked = 0;

  serial_frame_transmitter u_serial_frame_transmitter (
    .sys_clk(sys_clk), .srst(srst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .port_txd(port_txd),
    .txd_out(txd_out), .txd_override(txd_override), .rxd_in(txd_out),
    .transfer_clock_pin_in(1'b0), .transfer_clock_pin_out(xck_out),
    .transfer_clock_pin_oe(xck_oe));
  line_receiver u_line_receiver (.sys_clk(sys_clk), .line(txd_out), .bit_time(bt),
    .nbits(nb), .parity_mode(pm), .two_stop(ts), .got(got), .frame(frame));

  initial sys_clk = 1'b0;
  always #25 sys_clk = ~sys_clk;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Handshakes judged at the falling edge, acted on after the next rise
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] dt,
                     output logic [31:0] rd, output logic [1:0] rs);
    logic ha, hw, hd;
    @(posedge sys_clk);
    if (wr) begin
      awaddr <= {24'h0, a};
      wdata <= dt;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end else begin
      araddr <= {24'h0, a};
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    do begin
      @(negedge sys_clk);
      ha = wr ? awvalid & awready : arvalid & arready;
      hw = wvalid & wready;
      hd = wr ? bvalid : rvalid;
      rd = rdata;
      rs = wr ? bresp : rresp;
      @(posedge sys_clk);
      if (ha) begin
        awvalid <= 1'b0;
        arvalid <= 1'b0;
      end
      if (hw) wvalid <= 1'b0;
    end while (!hd);
    bready <= 1'b0;
    rready <= 1'b0;
  endtask

  task automatic send(input logic [2:0] sz, input logic [8:0] dt, output logic [7:0] rx);
    logic [8:0] dm;
    dm = dt & (9'h1ff >> (4'h9 - nb));
    rx = dm[7:0];
    expq.push_back({19'h0, 1'b0, 2'b11, pm[1] ? ^dm ^ pm[0] : 1'b1, dm});
    bus(1'b1, 8'h08, {28'h0, sz[2], dt[8], 2'b11}, q, r);
    bus(1'b1, 8'h00, {24'h0, dt[7:0]}, q, r);
  endtask

  task automatic done(input logic [7:0] rx, input logic [31:0] clr);
    int n;
    n = 0;
    do begin
      bus(1'b0, 8'h04, 32'h0, q, r);
      n++;
    end while (q[1] !== 1'b1 && n < 600);
    chk("txc_set", q[1], 1'b1);
    chk("ferr_clr", q[3], 1'b0);
    @(negedge sys_clk);
    chk("idle", txd_out, 1'b1);
    bus(1'b0, 8'h00, 32'h0, q, r);
    chk("rx_byte", q, {24'h0, rx});
    bus(1'b1, 8'h04, clr, q, r);
    bus(1'b0, 8'h04, 32'h0, q, r);
    chk("txc_clr", q[1], 1'b0);
  endtask

  always @(posedge sys_clk) begin
    if (got === 1'b1)
      chk("frame", {19'h0, frame}, expq.size() ? expq.pop_front() : 32'hffffffff);
  end

  initial begin
    repeat (40000) @(posedge sys_clk);
    error_cnt++;
    wrap_up();
  end

  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, wdata, araddr} = 96'h0;
    wstrb = 4'hf;
    port_txd = 1'b1;
    srst = 1'b1;
    seed = 32'ha724d827;
    {bt, nb, pm, ts} = {6'h10, 4'h8, 2'h0, 1'b0};
    repeat (16) @(posedge sys_clk);
    srst <= 1'b0;
    port_txd <= 1'b0;
    @(negedge sys_clk);
    chk("port_pin", txd_out, 1'b0);
    @(posedge sys_clk);
    port_txd <= 1'b1;
    bus(1'b0, 8'h04, 32'h0, q, r);
    chk("flags_rst", q[1:0], 2'b01);
    bus(1'b1, 8'h10, 32'h0, q, r);
    bus(1'b1, 8'h14, 32'h0, q, r);
    bus(1'b1, 8'h08, 32'h3, q, r);
    @(negedge sys_clk);
    chk("override", {txd_override, txd_out}, 2'b11);
    for (int k = 0; k < 5; k++)
      for (int p = 0; p < 3; p++) begin
        nb = k[3:0] + 4'h5;
        pm = (p == 0) ? 2'b00 : {1'b1, p == 2};
        ts = k[0] ^ p[0];
        bus(1'b1, 8'h0c, {27'h0, ts, pm, k[1:0] | {2{k == 4}}}, q, r);
        d = rnd();
        send((k == 4) ? 3'h7 : k[2:0], d[8:0], v);
        done(v, 32'h2);
      end
    {nb, pm, ts} = {4'h8, 2'b00, 1'b0};
    bus(1'b1, 8'h0c, 32'h3, q, r);
    d = rnd();
    send(3'h3, d[8:0], v);
    send(3'h3, d[17:9], v);
    bus(1'b0, 8'h04, 32'h0, q, r);
    chk("full", q[1:0], 2'b00);
    done(v, 32'h2);
    send(3'h3, d[26:18], v);
    bus(1'b1, 8'h08, 32'h2, q, r);
    done(v, 32'h2);
    @(negedge sys_clk);
    chk("released", txd_override, 1'b0);
    // Port pin sends ten low bits into the loopback: stop bit is zero
    expq.push_back(32'h00000a00);
    @(posedge sys_clk);
    port_txd <= 1'b0;
    repeat (160) @(posedge sys_clk);
    port_txd <= 1'b1;
    bus(1'b0, 8'h04, 32'h0, q, r);
    chk("ferr_set", q[3], 1'b1);
    bus(1'b1, 8'h08, 32'h3, q, r);
    bus(1'b1, 8'h0c, 32'h63, q, r);
    @(negedge sys_clk);
    chk("xck_oe", xck_oe, 1'b1);
    q[0] = xck_out;
    @(negedge sys_clk);
    chk("xck_run", xck_out, !q[0]);
    bus(1'b1, 8'h0c, 32'h3, q, r);
    bus(1'b1, 8'h10, 32'h2, q, r);
    bus(1'b1, 8'h04, 32'h10, q, r);
    bt = 6'd24;
    send(3'h3, d[8:0], v);
    done(v, 32'h12);
    bus(1'b1, 8'h40, 32'h0, q, r);
    chk("wr_unmapped", r, 2'h2);
    bus(1'b0, 8'h40, 32'h0, q, r);
    chk("rd_unmapped", r, 2'h2);
    chk("pending", 32'(expq.size()), 32'h0);
    wrap_up();
  end
endmodule // test_serial_frame_transmitter
